// File: core/boot_link_pkg.sv
`default_nettype none
package boot_link_pkg;
  // link bytes and commands
  localparam logic [7:0]  SYNC_BYTE        = 8'h86;
  localparam logic [7:0]  CMD_RAM_XFER     = 8'h10;
  localparam logic [7:0]  CMD_SUM          = 8'h20;
  localparam logic [7:0]  CMD_PINFO        = 8'h30;
  localparam logic [7:0]  CMD_PROTECT      = 8'h60;
  localparam logic [3:0]  ACK_OK           = 4'h0;
  localparam logic [3:0]  ACK_RX_ERR       = 4'h8;
  localparam logic [3:0]  ACK_BAD          = 4'h1;
  localparam logic [7:0]  ERASED_BYTE      = 8'hFF;
  // flash map
  localparam logic [23:0] FLASH_BASE       = 24'h040000;
  localparam logic [23:0] PW_ADDR          = 24'h04FEF4;
  localparam logic [23:0] RVEC_ADDR        = 24'h04FF00;
  localparam int          PW_BYTES         = 12;
  localparam int          RVEC_BYTES       = 3;
  localparam int          PW_CHECK_BYTES   = PW_BYTES + RVEC_BYTES;
  localparam int          FRAME_BYTES      = 13;
  localparam int          FLASH_SIZE_BYTES = 256 * 1024;
  // baud detection
  localparam int          TIMER_WIDTH      = 20;
  localparam int          SYNC_EDGE_THIRD  = 3;
  localparam int          SYNC_THIRD_SHIFT = 3;
  localparam int          MIN_BIT_CYCLES   = 4;
  localparam int          DATA_BITS        = 8;
  localparam int          PINFO_LEN        = 8;

  function automatic logic [7:0] ack_code(input logic [7:0] cmd, input logic [3:0] flags);
    return {cmd[7:4], flags};
  endfunction : ack_code

  function automatic logic [7:0] neg_cks(input logic [7:0] sum8);
    return 8'h00 - sum8;
  endfunction : neg_cks
endpackage : boot_link_pkg
`default_nettype wire

// File: core/byte_if.sv
`default_nettype none
interface byte_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_if
`default_nettype wire

// File: core/byte_buf2.sv
`default_nettype none
module byte_buf2 #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  // streams
  byte_if.snk       in_p,
  byte_if.src       out_p
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] cnt_reg;
  logic          wr_fire;
  logic          rd_fire;

  function automatic logic [PW-1:0] ptr_adv(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : ptr_adv

  assign in_p.ready  = (cnt_reg != CW'(DEPTH));
  assign out_p.valid = (cnt_reg != '0);
  assign out_p.data  = mem_reg[rd_ptr_reg];
  assign wr_fire     = in_p.valid && in_p.ready;
  assign rd_fire     = out_p.valid && out_p.ready;

  always_ff @(posedge mclk_i) begin
    if (wr_fire) begin
      mem_reg[wr_ptr_reg] <= in_p.data;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      if (wr_fire) wr_ptr_reg <= ptr_adv(wr_ptr_reg);
      if (rd_fire) rd_ptr_reg <= ptr_adv(rd_ptr_reg);
      cnt_reg <= cnt_reg + CW'(wr_fire) - CW'(rd_fire);
    end
  end

  a_buf_bound: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (out_p.valid && !out_p.ready) |=> (out_p.valid && $stable(out_p.data)))
    else $error("buffer lost a stored word");
endmodule : byte_buf2
`default_nettype wire

// File: core/serial_tx.sv
`default_nettype none
module serial_tx
  import boot_link_pkg::*;
#(
  parameter int BIT_W = 17
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  // bit timing
  input  wire logic [BIT_W-1:0] bit_period_i,
  // byte stream and line
  byte_if.snk                   in_p,
  output logic                  txd_o
);
  logic [8:0]       shift_reg;
  logic [3:0]       bits_reg;
  logic [BIT_W-1:0] cnt_reg;
  logic             busy_reg;

  assign in_p.ready = !busy_reg;

  // start, eight data bits lsb first, stop
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_reg <= '1;
      bits_reg  <= '0;
      cnt_reg   <= '0;
      busy_reg  <= 1'b0;
      txd_o     <= 1'b1;
    end else if (in_p.valid && !busy_reg) begin
      shift_reg <= {1'b1, in_p.data};
      bits_reg  <= 4'(DATA_BITS + 1);
      cnt_reg   <= bit_period_i - BIT_W'(1);
      busy_reg  <= 1'b1;
      txd_o     <= 1'b0;
    end else if (busy_reg) begin
      if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - BIT_W'(1);
      end else if (bits_reg == '0) begin
        busy_reg <= 1'b0;
      end else begin
        txd_o     <= shift_reg[0];
        shift_reg <= {1'b1, shift_reg[8:1]};
        bits_reg  <= bits_reg - 4'(1);
        cnt_reg   <= bit_period_i - BIT_W'(1);
      end
    end
  end

  a_tx_start_low: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (in_p.valid && in_p.ready) |=> (!txd_o && busy_reg))
    else $error("start bit not driven low");
endmodule : serial_tx
`default_nettype wire

// File: core/boot_auth_sum.sv
`default_nettype none
module boot_auth_sum
  import boot_link_pkg::*;
#(
  parameter int FLASH_BYTES = FLASH_SIZE_BYTES,
  parameter int TMR_W       = TIMER_WIDTH,
  parameter int PINFO_BYTES = PINFO_LEN
) (
  // clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     rst_b_i,
  // serial link
  input  wire logic                     rxd_i,
  output logic                          txd_o,
  // flash read port
  output logic                          flash_rd_o,
  output logic [23:0]                   flash_addr_o,
  input  wire logic [7:0]               flash_rdata_i,
  input  wire logic                     flash_ack_i,
  input  wire logic                     flash_busy_i,
  // product information
  input  wire logic [PINFO_BYTES*8-1:0] prod_info_i,
  // status
  output logic                          link_up_o,
  output logic                          sync_fail_o,
  output logic                          auth_pass_o,
  output logic [7:0]                    auth_cmd_o
);
  localparam int BIT_W = TMR_W - SYNC_THIRD_SHIFT;
  localparam int IDX_W = $clog2(FLASH_BYTES);
  typedef enum logic [3:0] {
    S_SYNC_WAIT, S_SYNC_MEAS, S_SYNC_CHK, S_SYNC_ACK, S_HALT, S_CMD, S_ACK_CMD, S_ECHO,
    S_PW_RX, S_PW_RD, S_PW_ACK, S_SUM_RD, S_SUM_HI, S_SUM_LO, S_PI_TX, S_CKS
  } state_t;
  state_t           st_reg;
  logic             rx_q1_reg, rx_q2_reg, rx_q3_reg, rx_lvl_reg, rx_lvl_d_reg, rx_edge, rx_fall;
  logic [TMR_W-1:0] timer_reg, t_fall_reg, sync_interval_second_reg, sync_interval_third_reg;
  logic [2:0]       edge_cnt_reg;
  logic [BIT_W-1:0] bit_period_reg, rx_cnt_reg;
  logic [TMR_W:0]   twice_second, third_ext, gap;
  logic             baud_ok, rx_busy_reg, rx_done_reg, rx_ferr_reg, rd_take, push_valid;
  logic [3:0]       rx_bit_reg, pw_flags;
  logic [7:0]       rx_shift_reg, rx_byte_reg, cmd_reg, rx_sum_reg;
  logic [7:0]       first_reg, cks_acc_reg, push_data;
  logic [IDX_W-1:0] idx_reg;
  logic [7:0]       pw_rx_reg [PW_BYTES];
  logic             rx_err_reg, mismatch_reg, all_same_reg, all_ff_reg, pw_err, push_fire;
  logic [15:0]      sum_reg;

  byte_if #(.W(8)) push_if ();
  byte_if #(.W(8)) line_if ();
  // synchroniser and level filter
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_q1_reg    <= 1'b1;
      rx_q2_reg    <= 1'b1;
      rx_q3_reg    <= 1'b1;
      rx_lvl_reg   <= 1'b1;
      rx_lvl_d_reg <= 1'b1;
    end else begin
      rx_q1_reg    <= rxd_i;
      rx_q2_reg    <= rx_q1_reg;
      rx_q3_reg    <= rx_q2_reg;
      rx_lvl_d_reg <= rx_lvl_reg;
      if (rx_q2_reg == rx_q3_reg) rx_lvl_reg <= rx_q3_reg;
    end
  end

  assign rx_edge = rx_lvl_reg != rx_lvl_d_reg;
  assign rx_fall = rx_lvl_d_reg && !rx_lvl_reg;
  // free-running timer
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) timer_reg <= '0;
    else timer_reg <= timer_reg + TMR_W'(1);
  end
  // sync byte measurement: falls at 0 and 4 bits, rises at 2 and 8 bits
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      t_fall_reg               <= '0;
      edge_cnt_reg             <= '0;
      sync_interval_second_reg <= '0;
      sync_interval_third_reg  <= '0;
      bit_period_reg           <= '0;
    end else if (st_reg == S_SYNC_WAIT && rx_fall) begin
      t_fall_reg   <= timer_reg;
      edge_cnt_reg <= 3'(1);
    end else if (st_reg == S_SYNC_MEAS && rx_edge) begin
      edge_cnt_reg <= edge_cnt_reg + 3'(1);
      if (edge_cnt_reg == 3'(SYNC_EDGE_THIRD - 1))
        sync_interval_second_reg <= timer_reg - t_fall_reg;
      if (edge_cnt_reg == 3'(SYNC_EDGE_THIRD))
        sync_interval_third_reg <= timer_reg - t_fall_reg;
    end else if (st_reg == S_SYNC_CHK) begin
      bit_period_reg <= sync_interval_third_reg[TMR_W-1:SYNC_THIRD_SHIFT];
    end
  end
  // second interval is half the third within a quarter
  assign twice_second = {sync_interval_second_reg, 1'b0};
  assign third_ext    = {1'b0, sync_interval_third_reg};
  assign gap          = (twice_second > third_ext) ? twice_second - third_ext
                                                   : third_ext - twice_second;
  assign baud_ok      = (sync_interval_third_reg[TMR_W-1:SYNC_THIRD_SHIFT]
                         >= BIT_W'(MIN_BIT_CYCLES)) && (gap <= (third_ext >> 2));
  // receiver, enabled only once the link is up
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_busy_reg  <= 1'b0;
      rx_done_reg  <= 1'b0;
      rx_ferr_reg  <= 1'b0;
      rx_cnt_reg   <= '0;
      rx_bit_reg   <= '0;
      rx_shift_reg <= '0;
      rx_byte_reg  <= '0;
    end else begin
      rx_done_reg <= 1'b0;
      if (!rx_busy_reg) begin
        if (link_up_o && !rx_lvl_reg) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg  <= bit_period_reg >> 1;
          rx_bit_reg  <= '0;
        end
      end else if (rx_cnt_reg != '0) begin
        rx_cnt_reg <= rx_cnt_reg - BIT_W'(1);
      end else begin
        rx_cnt_reg <= bit_period_reg - BIT_W'(1);
        rx_bit_reg <= rx_bit_reg + 4'(1);
        if (rx_bit_reg == '0) begin
          if (rx_lvl_reg) rx_busy_reg <= 1'b0;
        end else if (rx_bit_reg <= 4'(DATA_BITS)) begin
          rx_shift_reg <= {rx_lvl_reg, rx_shift_reg[7:1]};
        end else begin
          rx_busy_reg <= 1'b0;
          rx_done_reg <= 1'b1;
          rx_byte_reg <= rx_shift_reg;
          rx_ferr_reg <= !rx_lvl_reg;
        end
      end
    end
  end
  // control sequence
  assign rd_take = flash_rd_o && flash_ack_i;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg  <= S_SYNC_WAIT;
      cmd_reg <= '0;
    end else begin
      unique case (st_reg)
        S_SYNC_WAIT: if (rx_fall) st_reg <= S_SYNC_MEAS;
        S_SYNC_MEAS: if (rx_edge && edge_cnt_reg == 3'(SYNC_EDGE_THIRD)) st_reg <= S_SYNC_CHK;
        S_SYNC_CHK:  st_reg <= baud_ok ? S_SYNC_ACK : S_HALT;
        S_SYNC_ACK:  if (push_fire) st_reg <= S_CMD;
        S_HALT:      st_reg <= S_HALT;
        S_CMD: begin
          if (rx_done_reg) begin
            cmd_reg <= rx_byte_reg;
            if (rx_ferr_reg) st_reg <= S_ACK_CMD;
            else if (rx_byte_reg inside {CMD_RAM_XFER, CMD_PROTECT, CMD_SUM, CMD_PINFO})
              st_reg <= S_ECHO;
            else st_reg <= S_ACK_CMD;
          end
        end
        S_ACK_CMD:   if (push_fire) st_reg <= S_CMD;
        S_ECHO: begin
          if (push_fire) begin
            if (cmd_reg == CMD_SUM) st_reg <= S_SUM_RD;
            else if (cmd_reg == CMD_PINFO) st_reg <= S_PI_TX;
            else st_reg <= S_PW_RX;
          end
        end
        S_PW_RX:  if (rx_done_reg && idx_reg == IDX_W'(FRAME_BYTES - 1)) st_reg <= S_PW_RD;
        S_PW_RD:  if (rd_take && idx_reg == IDX_W'(PW_CHECK_BYTES - 1)) st_reg <= S_PW_ACK;
        S_PW_ACK: if (push_fire) st_reg <= S_CMD;
        S_SUM_RD: if (rd_take && idx_reg == IDX_W'(FLASH_BYTES - 1)) st_reg <= S_SUM_HI;
        S_SUM_HI: if (push_fire) st_reg <= S_SUM_LO;
        S_SUM_LO: if (push_fire) st_reg <= S_CKS;
        S_PI_TX:  if (push_fire && idx_reg == IDX_W'(PINFO_BYTES - 1)) st_reg <= S_CKS;
        S_CKS:    if (push_fire) st_reg <= S_CMD;
      endcase
    end
  end
  // shared byte index
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) idx_reg <= '0;
    else if (st_reg == S_ECHO) idx_reg <= '0;
    else if (st_reg == S_PW_RX && rx_done_reg)
      idx_reg <= (idx_reg == IDX_W'(FRAME_BYTES - 1)) ? '0 : idx_reg + IDX_W'(1);
    else if (rd_take || (st_reg == S_PI_TX && push_fire)) idx_reg <= idx_reg + IDX_W'(1);
  end
  // flash reads, held off while the array is busy
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flash_rd_o   <= 1'b0;
      flash_addr_o <= '0;
    end else if (flash_rd_o) begin
      if (flash_ack_i) flash_rd_o <= 1'b0;
    end else if ((st_reg == S_PW_RD || st_reg == S_SUM_RD) && !flash_busy_i) begin
      flash_rd_o   <= 1'b1;
      flash_addr_o <= ((st_reg == S_PW_RD) ? PW_ADDR : FLASH_BASE) + 24'(idx_reg);
    end
  end
  // password frame and verification
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_sum_reg   <= '0;
      rx_err_reg   <= 1'b0;
      mismatch_reg <= 1'b0;
      all_same_reg <= 1'b1;
      all_ff_reg   <= 1'b1;
      first_reg    <= '0;
      for (int i = 0; i < PW_BYTES; i++) pw_rx_reg[i] <= '0;
    end else if (st_reg == S_ECHO) begin
      rx_sum_reg   <= '0;
      rx_err_reg   <= 1'b0;
      mismatch_reg <= 1'b0;
      all_same_reg <= 1'b1;
      all_ff_reg   <= 1'b1;
    end else if (st_reg == S_PW_RX && rx_done_reg) begin
      rx_sum_reg <= rx_sum_reg + rx_byte_reg;
      rx_err_reg <= rx_err_reg | rx_ferr_reg;
      if (idx_reg < IDX_W'(PW_BYTES)) pw_rx_reg[idx_reg[3:0]] <= rx_byte_reg;
    end else if (st_reg == S_PW_RD && rd_take) begin
      all_ff_reg <= all_ff_reg && (flash_rdata_i == ERASED_BYTE);
      if (idx_reg < IDX_W'(PW_BYTES)) begin
        if (flash_rdata_i != pw_rx_reg[idx_reg[3:0]]) mismatch_reg <= 1'b1;
        if (idx_reg == '0) first_reg <= flash_rdata_i;
        else if (flash_rdata_i != first_reg) all_same_reg <= 1'b0;
      end
    end
  end

  assign pw_err   = mismatch_reg || (all_same_reg && !all_ff_reg);
  assign pw_flags = rx_err_reg ? ACK_RX_ERR
                  : ((rx_sum_reg != 8'h00) || pw_err) ? ACK_BAD : ACK_OK;
  // flash sum and answer checksum
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sum_reg     <= '0;
      cks_acc_reg <= '0;
    end else if (st_reg == S_ECHO) begin
      sum_reg     <= '0;
      cks_acc_reg <= '0;
    end else begin
      if (st_reg == S_SUM_RD && rd_take) sum_reg <= sum_reg + 16'(flash_rdata_i);
      if (push_fire && st_reg inside {S_SUM_HI, S_SUM_LO, S_PI_TX})
        cks_acc_reg <= cks_acc_reg + push_data;
    end
  end
  // bytes toward the transmitter
  always_comb begin
    push_valid = 1'b1;
    push_data  = 8'h00;
    unique case (st_reg)
      S_SYNC_ACK: push_data = SYNC_BYTE;
      S_ACK_CMD:  push_data = ack_code(cmd_reg, rx_ferr_reg ? ACK_RX_ERR : ACK_BAD);
      S_ECHO:     push_data = cmd_reg;
      S_PW_ACK:   push_data = ack_code(cmd_reg, pw_flags);
      S_SUM_HI:   push_data = sum_reg[15:8];
      S_SUM_LO:   push_data = sum_reg[7:0];
      S_PI_TX:    push_data = prod_info_i[idx_reg*8 +: 8];
      S_CKS:      push_data = neg_cks(cks_acc_reg);
      default:    push_valid = 1'b0;
    endcase
  end
  assign push_if.valid = push_valid;
  assign push_if.data  = push_data;
  assign push_fire     = push_valid && push_if.ready;
  byte_buf2 #(.W(8), .DEPTH(2)) u_buf (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .in_p    (push_if),
    .out_p   (line_if)
  );
  serial_tx #(.BIT_W(BIT_W)) u_tx (
    .mclk_i       (mclk_i),
    .rst_b_i      (rst_b_i),
    .bit_period_i (bit_period_reg),
    .in_p         (line_if),
    .txd_o        (txd_o)
  );
  // status outputs
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link_up_o   <= 1'b0;
      sync_fail_o <= 1'b0;
      auth_pass_o <= 1'b0;
      auth_cmd_o  <= '0;
    end else begin
      auth_pass_o <= 1'b0;
      if (st_reg == S_SYNC_ACK && push_fire) link_up_o <= 1'b1;
      if (st_reg == S_HALT) sync_fail_o <= 1'b1;
      if (st_reg == S_PW_ACK && push_fire && pw_flags == ACK_OK) begin
        auth_pass_o <= 1'b1;
        auth_cmd_o  <= cmd_reg;
      end
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_sync_measured;
    st_reg == S_SYNC_CHK && baud_ok;
  endsequence
  sequence s_sync_reply;
    st_reg == S_SYNC_ACK && push_fire && push_data == SYNC_BYTE;
  endsequence

  a_sync_reply: assert property (s_sync_measured |=> s_sync_reply)
    else $error("sync answer missing");
  a_sync_halt: assert property (
    (st_reg == S_SYNC_CHK && !baud_ok) |=> (!push_valid && st_reg == S_HALT) [*8])
    else $error("failed sync still talks");
  a_first_not_data: assert property (!link_up_o |-> !rx_done_reg)
    else $error("sync byte taken as data");
  a_interval_latch: assert property (
    (st_reg == S_SYNC_MEAS && rx_edge && edge_cnt_reg == 3'(SYNC_EDGE_THIRD - 1))
    |=> sync_interval_second_reg == $past(timer_reg) - $past(t_fall_reg))
    else $error("interval not latched");
  a_echo_cmd: assert property ((st_reg == S_ECHO && push_fire) |-> push_data == cmd_reg)
    else $error("command not echoed");
  a_ack_nibble: assert property (
    (push_fire && st_reg inside {S_ACK_CMD, S_PW_ACK}) |-> push_data[7:4] == cmd_reg[7:4])
    else $error("ack nibble wrong");
  a_pw_mismatch: assert property (
    (st_reg == S_PW_ACK && push_fire && mismatch_reg) |-> push_data[0] || push_data[3])
    else $error("mismatch not flagged");
  a_same_err: assert property (
    (st_reg == S_PW_ACK && push_fire && all_same_reg && !all_ff_reg) |-> push_data[0] || push_data[3])
    else $error("uniform password accepted");
  a_blank_ok: assert property (
    (st_reg == S_PW_ACK && push_fire && !rx_err_reg && rx_sum_reg == 8'h00
     && !mismatch_reg && all_ff_reg) |-> push_data == cmd_reg)
    else $error("blank device refused");
  a_sum_order: assert property ((st_reg == S_SUM_HI && push_fire)
    |-> push_data == sum_reg[15:8] ##1 (push_valid && push_data == $past(sum_reg[7:0])))
    else $error("sum byte order wrong");
  a_cks_zero: assert property ((st_reg == S_CKS && push_fire && cmd_reg == CMD_SUM)
    |-> 8'(push_data + sum_reg[15:8] + sum_reg[7:0]) == 8'h00)
    else $error("checksum wrong");
  a_no_read_busy: assert property ($rose(flash_rd_o) |-> !$past(flash_busy_i))
    else $error("flash read while busy");
endmodule : boot_auth_sum
`default_nettype wire

// File: testbench/host_uart_model.sv
`default_nettype none
module host_uart_model #(
  parameter int BIT = 16
) (
  input  wire logic mclk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rxq[$];
  logic [7:0] sh;
  initial rxd_o = 1'b1;
  // start, eight bits lsb first, stop
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      rxd_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (BIT) @(posedge mclk_i);
    end
  endtask : send
  // frame with its stop bit held low, then one idle bit
  task automatic send_bad_stop(input logic [7:0] b);
    for (int i = 0; i < 11; i++) begin
      rxd_o <= (i == 0 || i == 9) ? 1'b0 : (i == 10) ? 1'b1 : b[i-1];
      repeat (BIT) @(posedge mclk_i);
    end
  endtask : send_bad_stop
  // device bytes sampled mid-bit
  initial begin
    forever begin
      @(negedge txd_i);
      repeat (BIT / 2) @(posedge mclk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge mclk_i);
        sh[i] = txd_i;
      end
      rxq.push_back(sh);
      repeat (BIT) @(posedge mclk_i);
    end
  end
endmodule : host_uart_model
`default_nettype wire

// File: testbench/boot_auth_sum_tb.sv
`default_nettype none
module boot_auth_sum_tb;
  import boot_link_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NB  = 16;
  localparam int BIT = 16;
  logic        mclk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        rxd, txd, rd, link_up, sync_fail, pass;
  logic        ack = 1'b0;
  logic        busy = 1'b0;
  logic [23:0] addr;
  logic [7:0]  rdata = 8'h00;
  logic [7:0]  acmd, got;
  logic [15:0] pinfo = 16'h0000;
  logic [7:0]  mem [logic [23:0]];
  logic [7:0]  pw [12];
  int          miscompares = 0;
  int          checks = 0;
  int          cyc = 0;
  int          passes = 0;
  always #5 mclk_i = ~mclk_i;
  boot_auth_sum #(.FLASH_BYTES(NB), .PINFO_BYTES(2)) i_boot_auth_sum (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .rxd_i(rxd), .txd_o(txd), .flash_rd_o(rd),
    .flash_addr_o(addr), .flash_rdata_i(rdata), .flash_ack_i(ack), .flash_busy_i(busy),
    .prod_info_i(pinfo), .link_up_o(link_up), .sync_fail_o(sync_fail),
    .auth_pass_o(pass), .auth_cmd_o(acmd));
  host_uart_model #(.BIT(BIT)) i_host_uart_model (.mclk_i(mclk_i), .txd_i(txd), .rxd_o(rxd));
  // flash with random latency and busy spells
  always @(posedge mclk_i) begin
    busy <= ($urandom % 6) == 0;
    ack <= rd && !ack && !busy && ($urandom % 3) == 0;
    rdata <= mem.exists(addr) ? mem[addr] : 8'hA5;
    if (pass === 1'b1) passes++;
    cyc++;
    if (cyc > 60000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic expect_byte(input logic [7:0] exp);
    int n = 0;
    while (i_host_uart_model.rxq.size() == 0 && n < 60 * BIT) begin
      @(posedge mclk_i);
      n++;
    end
    got = (n < 60 * BIT) ? i_host_uart_model.rxq.pop_front() : 8'hXX;
    check({8'h00, got}, {8'h00, exp});
  endtask : expect_byte
  function automatic logic [7:0] cks(input logic [7:0] a, input logic [7:0] b);
    return 8'h00 - a - b;
  endfunction : cks
  function automatic logic [15:0] flash_sum();
    logic [15:0] s = 16'h0000;
    for (int a = 0; a < NB; a++) s += {8'h00, mem[FLASH_BASE + 24'(a)]};
    return s;
  endfunction : flash_sum
  // stored password and reset vector
  task automatic fill(input logic [7:0] v, input bit rnd, input logic [7:0] rv);
    for (int i = 0; i < 15; i++) begin
      if (i < 12) pw[i] = rnd ? {4'(i), 4'($urandom)} : v;
      mem[PW_ADDR + 24'(i)] = (i < 12) ? pw[i] : rv;
    end
  endtask : fill
  // bad: index of wrong byte, 12 for checksum, 13 for a broken stop bit, -1 none
  task automatic pw_frame(input logic [7:0] cmd, input int bad, input logic [7:0] exp_ack);
    logic [7:0] s = 8'h00;
    logic [7:0] b;
    i_host_uart_model.send(cmd);
    expect_byte(cmd);
    for (int i = 0; i < 12; i++) begin
      b = pw[i] ^ ((i == bad) ? 8'h01 : 8'h00);
      s += b;
      if (i == 0 && bad == 13) i_host_uart_model.send_bad_stop(b);
      else i_host_uart_model.send(b);
    end
    i_host_uart_model.send(8'h00 - s + ((bad == 12) ? 8'h01 : 8'h00));
    expect_byte(exp_ack);
  endtask : pw_frame
  initial begin
    void'($urandom(32'h4F2C6ACF));
    for (int a = 0; a < NB; a++) mem[FLASH_BASE + 24'(a)] = 8'($urandom);
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    pinfo <= 16'($urandom);
    repeat (4) @(posedge mclk_i);
    i_host_uart_model.send(SYNC_BYTE);
    expect_byte(SYNC_BYTE);
    check({15'h0, link_up}, 16'h0001);
    i_host_uart_model.send(CMD_SUM);
    expect_byte(CMD_SUM);
    expect_byte(8'(flash_sum() >> 8));
    expect_byte(8'(flash_sum()));
    expect_byte(cks(8'(flash_sum() >> 8), 8'(flash_sum())));
    i_host_uart_model.send(CMD_PINFO);
    expect_byte(CMD_PINFO);
    expect_byte(pinfo[7:0]);
    expect_byte(pinfo[15:8]);
    expect_byte(cks(pinfo[7:0], pinfo[15:8]));
    i_host_uart_model.send(8'h40);
    expect_byte(8'h41);
    i_host_uart_model.send_bad_stop(CMD_SUM);
    expect_byte(8'h28);
    fill(8'h00, 1'b1, 8'h00);
    pw_frame(CMD_PROTECT, -1, 8'h60);
    check({8'h00, acmd}, {8'h00, CMD_PROTECT});
    pw_frame(CMD_RAM_XFER, 11, 8'h11);
    pw_frame(CMD_PROTECT, 12, 8'h61);
    pw_frame(CMD_PROTECT, 13, 8'h68);
    fill(8'h5A, 1'b0, 8'h00);
    pw_frame(CMD_RAM_XFER, -1, 8'h11);
    fill(ERASED_BYTE, 1'b0, ERASED_BYTE);
    pw_frame(CMD_RAM_XFER, -1, 8'h10);
    fill(ERASED_BYTE, 1'b0, 8'h00);
    pw_frame(CMD_PROTECT, -1, 8'h61);
    check(16'(passes), 16'd2);
    check({15'h0, sync_fail}, 16'h0000);
    // second reset, then a sync byte whose intervals do not fit
    rst_b_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    check({15'h0, link_up}, 16'h0000);
    repeat (3) @(posedge mclk_i);
    i_host_uart_model.send(8'hFA);
    repeat (40 * BIT) @(posedge mclk_i);
    check({15'h0, sync_fail}, 16'h0001);
    check(16'(i_host_uart_model.rxq.size()), 16'h0000);
    give_verdict();
  end
endmodule : boot_auth_sum_tb
`default_nettype wire
